// *** design/scs_pkg.sv ***
// shared constants and types of the serial port configuration and status register
package scs_pkg;
   // register location on the special function register bus
   localparam logic [7:0] SCS_CFG_ADDR = 8'hA1;
   // field positions
   localparam int SCS_BIT_ACTIVE = 7;
   localparam int SCS_BIT_ROLE = 6;
   localparam int SCS_BIT_PHASE = 5;
   localparam int SCS_BIT_POL = 4;
   localparam int SCS_BIT_SEL = 3;
   localparam int SCS_BIT_RAW = 2;
   localparam int SCS_BIT_SHIFT_REG_EMPTY = 1;
   localparam int SCS_BIT_RX_BUFFER_EMPTY = 0;
   localparam logic [7:0] SCS_CFG_RESET = 8'h07;
   localparam logic [7:0] SCS_UNMAPPED_READ = 8'h00;
   // timing, system clock of 40 MHz
   localparam int SCS_CLK_PERIOD_NS = 25;
   localparam int SCS_DEGLITCH_NS = 50;
   localparam int SCS_DEGLITCH_CYC = (SCS_DEGLITCH_NS + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS;
   localparam int SCS_SCK_HALF_NS = 100;
   localparam int SCS_SCK_HALF_CYC = SCS_SCK_HALF_NS / SCS_CLK_PERIOD_NS;
   localparam int SCS_MISO_LEAD_CYC = 1;
   localparam int SCS_BYTE_BITS = 8;
   localparam int SCS_HALVES = 2 * SCS_BYTE_BITS;
   typedef enum logic [1:0]
   {
      SCS_ST_IDLE = 2'b00,
      SCS_ST_RUN = 2'b01,
      SCS_ST_DONE = 2'b11
   } scs_state_t;
endpackage

// *** design/scs_sync.sv ***
// two-flop synchroniser for a vector of levels
`timescale 1ns/100ps
module scs_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] dout_reg;
   logic [WIDTH-1:0] dout_next;

   initial
   begin
      if (WIDTH < 1)
         $error("scs_sync width must be at least one");
   end

   always_comb
   begin
      meta_next = din;
      dout_next = meta_reg;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= RST_VAL;
         dout_reg <= RST_VAL;
      end
      else
      begin
         meta_reg <= meta_next;
         dout_reg <= dout_next;
      end
   end

   assign dout = dout_reg;
endmodule

// *** design/scs_target.sv ***
// target-side shift engine running on the external serial clock
`timescale 1ns/100ps
module scs_target
   import scs_pkg::*;
(
   input wire logic link_sck,
   input wire logic target_select_n,
   input wire logic sys_rst,
   input wire logic cfg_pol,
   input wire logic cfg_pha,
   input wire logic mosi_i,
   input wire logic [7:0] tx_hold,
   input wire logic tx_req,
   output logic tx_ack,
   output logic [7:0] rx_hold,
   output logic rx_toggle,
   output logic miso_o
);
   logic shift_clk;
   logic tx_req_s;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [7:0] in_reg;
   logic [7:0] in_next;
   logic [7:0] hold_reg;
   logic [7:0] hold_next;
   logic tog_reg;
   logic tog_next;
   logic [7:0] out_reg;
   logic [7:0] out_next;
   logic ack_reg;
   logic ack_next;
   logic [7:0] trail_hold_reg;
   logic [7:0] trail_hold_next;
   logic trail_tog_reg;
   logic trail_tog_next;

   // sampling edge is rising when polarity equals phase; config must stay put during a frame
   assign shift_clk = link_sck ^ (cfg_pol ^ cfg_pha);

   // the serial clock stands still between frames, so the request is seen at the next frame
   scs_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync
   (
      .clk(shift_clk),
      .rst(sys_rst),
      .din(tx_req),
      .dout(tx_req_s)
   );

   always_comb
   begin
      cnt_next = cnt_reg + 3'd1;
      in_next = {in_reg[6:0], mosi_i};
      hold_next = hold_reg;
      tog_next = tog_reg;
      // with phase one the eighth sample is also the last edge of the byte
      if (cfg_pha && cnt_reg == 3'(SCS_BYTE_BITS - 1))
      begin
         hold_next = {in_reg[6:0], mosi_i};
         tog_next = ~tog_reg;
      end
   end

   // bit position is ended by the frame's own select signal
   always_ff @(posedge shift_clk or posedge target_select_n)
   begin
      if (target_select_n)
      begin
         cnt_reg <= 3'd0;
         in_reg <= 8'h00;
      end
      else
      begin
         cnt_reg <= cnt_next;
         in_reg <= in_next;
      end
   end

   always_ff @(posedge shift_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hold_reg <= 8'h00;
         tog_reg <= 1'b0;
      end
      else
      begin
         hold_reg <= hold_next;
         tog_reg <= tog_next;
      end
   end

   always_comb
   begin
      out_next = {out_reg[6:0], 1'b0};
      ack_next = ack_reg;
      trail_hold_next = trail_hold_reg;
      trail_tog_next = trail_tog_reg;
      if (cnt_reg == 3'd1)
      begin
         out_next = {tx_hold[6:0], 1'b0};
         ack_next = tx_req_s;
      end
      // phase zero owes a trailing edge; flagging earlier would let that edge clear it
      if (!cfg_pha && !target_select_n && cnt_reg == 3'd0)
      begin
         trail_hold_next = in_reg;
         trail_tog_next = ~trail_tog_reg;
      end
   end

   always_ff @(negedge shift_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         out_reg <= 8'h00;
         ack_reg <= 1'b0;
         trail_hold_reg <= 8'h00;
         trail_tog_reg <= 1'b0;
      end
      else
      begin
         out_reg <= out_next;
         ack_reg <= ack_next;
         trail_hold_reg <= trail_hold_next;
         trail_tog_reg <= trail_tog_next;
      end
   end

   // first bit must be on the line before the first edge when phase is zero
   assign miso_o = (cnt_reg == 3'd0) ? tx_hold[7] : out_reg[7];
   assign tx_ack = ack_reg;
   // only one of the two toggles moves per byte, so their xor never glitches
   assign rx_hold = cfg_pha ? hold_reg : trail_hold_reg;
   assign rx_toggle = tog_reg ^ trail_tog_reg;
endmodule

// *** design/scs_top.sv ***
// serial port configuration and status register with controller and target engines
// Summary of operation
// - busy bit reads 1 during any transfer, controller or target, else 0.
// - role bit 0 means target, 1 means controller driving serial clock.
// - phase bit picks first or second clock edge as bit centre.
// - polarity bit picks idle clock level, low for 0, high for 1.
// - selected flag is 1 while de-glitched select pin is low.
// - raw select bit reads the unfiltered select pin level.
// - target shift-empty flag sets when a byte completes into receive buffer.
// - shift-empty flag clears on transmit byte load or clock transition.
// - target receive-empty flag is 0 while unread data waits, 1 after read.
// - in controller role both empty flags read 1.
// - target samples controller data at each bit centre.
// - controller samples target data one system clock before bit end.
`timescale 1ns/100ps
module scs_top
   import scs_pkg::*;
#(
   parameter int HALF_CYC = SCS_SCK_HALF_CYC,
   parameter int DEGLITCH_CYC = SCS_DEGLITCH_CYC
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic tx_load,
   input wire logic [7:0] tx_data,
   input wire logic rx_read,
   output logic [7:0] rx_data,
   input wire logic link_sck,
   output logic sck_o,
   output logic sck_oe,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   input wire logic target_select_n
);
   localparam int CW = $clog2(HALF_CYC + 1);
   localparam int DW = $clog2(DEGLITCH_CYC + 1);

   initial
   begin
      if (HALF_CYC < SCS_MISO_LEAD_CYC + 1)
         $error("half period too short for the sampling lead");
      if (DEGLITCH_CYC < 1)
         $error("deglitch length must be at least one cycle");
   end

   logic [2:0] pins_s;
   logic nss_s;
   logic sck_s;
   logic miso_s;
   logic [1:0] tog_s;
   logic rxt_s;
   logic ack_s;
   logic tx_ack_l;
   logic rx_tog_l;
   logic [7:0] rx_hold_l;

   scs_sync #(.WIDTH(3), .RST_VAL(3'b100)) u_pin_sync
   (
      .clk(core_clk),
      .rst(sys_rst),
      .din({target_select_n, link_sck, miso_i}),
      .dout(pins_s)
   );

   scs_sync #(.WIDTH(2), .RST_VAL(2'b00)) u_tog_sync
   (
      .clk(core_clk),
      .rst(sys_rst),
      .din({rx_tog_l, tx_ack_l}),
      .dout(tog_s)
   );

   assign nss_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign miso_s = pins_s[0];
   assign rxt_s = tog_s[1];
   assign ack_s = tog_s[0];

   // configuration and status state
   logic role_reg;
   logic role_next;
   logic pha_reg;
   logic pha_next;
   logic pol_reg;
   logic pol_next;
   logic shift_reg_empty_reg;
   logic shift_reg_empty_next;
   logic rx_buffer_empty_reg;
   logic rx_buffer_empty_next;
   logic filt_reg;
   logic filt_next;
   logic lvl_reg;
   logic lvl_next;
   logic [DW-1:0] dg_reg;
   logic [DW-1:0] dg_next;
   logic sck_d_reg;
   logic rxt_d_reg;
   logic ack_d_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] rxd_reg;
   logic [7:0] rxd_next;
   logic [7:0] txh_reg;
   logic [7:0] txh_next;
   logic txr_reg;
   logic txr_next;
   logic miso_oe_reg;
   logic miso_oe_next;
   logic cfg_hit;
   logic sck_edge;
   logic rx_event;
   logic ack_event;
   logic sel_flag;
   logic busy;
   logic ctrl_done;

   // controller state
   scs_state_t state_reg;
   scs_state_t state_next;
   logic [CW-1:0] cyc_reg;
   logic [CW-1:0] cyc_next;
   logic [4:0] half_reg;
   logic [4:0] half_next;
   logic sck_reg;
   logic sck_next;
   logic [7:0] osh_reg;
   logic [7:0] osh_next;
   logic [7:0] ish_reg;
   logic [7:0] ish_next;
   logic sample_half;
   logic shift_half;
   logic [4:0] last_half;

   assign cfg_hit = (sfr_addr == SCS_CFG_ADDR);
   assign sck_edge = sck_s ^ sck_d_reg;
   assign rx_event = rxt_s ^ rxt_d_reg;
   assign ack_event = ack_s ^ ack_d_reg;
   assign sel_flag = ~filt_reg;
   assign busy = role_reg ? (state_reg != SCS_ST_IDLE) : sel_flag;
   assign ctrl_done = (state_reg == SCS_ST_DONE);

   always_comb
   begin
      role_next = role_reg;
      pha_next = pha_reg;
      pol_next = pol_reg;
      if (sfr_wr && cfg_hit)
      begin
         // status bits ignore written values
         role_next = sfr_wdata[SCS_BIT_ROLE];
         pha_next = sfr_wdata[SCS_BIT_PHASE];
         pol_next = sfr_wdata[SCS_BIT_POL];
      end
      // the select pin must hold a level for the whole window before the flag follows
      lvl_next = nss_s;
      dg_next = dg_reg;
      filt_next = filt_reg;
      if (nss_s != lvl_reg)
         dg_next = '0;
      else if (dg_reg < DW'(DEGLITCH_CYC))
         dg_next = dg_reg + DW'(1);
      else
         filt_next = lvl_reg;
      shift_reg_empty_next = shift_reg_empty_reg;
      rx_buffer_empty_next = rx_buffer_empty_reg;
      if (role_reg)
      begin
         shift_reg_empty_next = 1'b1;
         rx_buffer_empty_next = 1'b1;
      end
      else
      begin
         if (ack_event || sck_edge)
            shift_reg_empty_next = 1'b0;
         if (rx_event)
            shift_reg_empty_next = 1'b1;
         if (rx_read)
            rx_buffer_empty_next = 1'b1;
         if (rx_event)
            rx_buffer_empty_next = 1'b0;
      end
      rxd_next = rxd_reg;
      if (rx_event && !role_reg)
         rxd_next = rx_hold_l;
      else if (ctrl_done)
         rxd_next = ish_reg;
      txh_next = txh_reg;
      txr_next = txr_reg;
      if (tx_load && !role_reg)
      begin
         txh_next = tx_data;
         txr_next = ~txr_reg;
      end
      rdata_next = rdata_reg;
      if (sfr_rd)
      begin
         if (cfg_hit)
            rdata_next = {busy, role_reg, pha_reg, pol_reg, sel_flag, nss_s,
                          shift_reg_empty_reg | role_reg, rx_buffer_empty_reg | role_reg};
         else
            rdata_next = SCS_UNMAPPED_READ;
      end
      miso_oe_next = !role_reg && sel_flag;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         role_reg <= SCS_CFG_RESET[SCS_BIT_ROLE];
         pha_reg <= SCS_CFG_RESET[SCS_BIT_PHASE];
         pol_reg <= SCS_CFG_RESET[SCS_BIT_POL];
         shift_reg_empty_reg <= SCS_CFG_RESET[SCS_BIT_SHIFT_REG_EMPTY];
         rx_buffer_empty_reg <= SCS_CFG_RESET[SCS_BIT_RX_BUFFER_EMPTY];
         filt_reg <= 1'b1;
         lvl_reg <= 1'b1;
         dg_reg <= '0;
         sck_d_reg <= 1'b0;
         rxt_d_reg <= 1'b0;
         ack_d_reg <= 1'b0;
         rdata_reg <= SCS_CFG_RESET;
         rxd_reg <= 8'h00;
         txh_reg <= 8'h00;
         txr_reg <= 1'b0;
         miso_oe_reg <= 1'b0;
      end
      else
      begin
         role_reg <= role_next;
         pha_reg <= pha_next;
         pol_reg <= pol_next;
         shift_reg_empty_reg <= shift_reg_empty_next;
         rx_buffer_empty_reg <= rx_buffer_empty_next;
         filt_reg <= filt_next;
         lvl_reg <= lvl_next;
         dg_reg <= dg_next;
         sck_d_reg <= sck_s;
         rxt_d_reg <= rxt_s;
         ack_d_reg <= ack_s;
         rdata_reg <= rdata_next;
         rxd_reg <= rxd_next;
         txh_reg <= txh_next;
         txr_reg <= txr_next;
         miso_oe_reg <= miso_oe_next;
      end
   end

   // controller: phase one adds a trailing half so the last bit gets a full period
   assign last_half = 5'(SCS_HALVES - 1) + 5'(pha_reg);
   assign sample_half = pha_reg ? (!half_reg[0] && half_reg >= 5'd2) : half_reg[0];
   assign shift_half = pha_reg ? (!half_reg[0] && half_reg >= 5'd2 && half_reg <= 5'd14)
                               : (half_reg[0] && half_reg < 5'd15);

   always_comb
   begin
      state_next = state_reg;
      cyc_next = cyc_reg;
      half_next = half_reg;
      sck_next = sck_reg;
      osh_next = osh_reg;
      ish_next = ish_reg;
      unique case (state_reg)
         SCS_ST_IDLE:
         begin
            sck_next = pol_reg;
            if (tx_load && role_reg)
            begin
               state_next = SCS_ST_RUN;
               osh_next = tx_data;
               cyc_next = '0;
               half_next = 5'd0;
            end
         end
         SCS_ST_RUN:
         begin
            // a synchronised sample late in the bit leaves the target the most settling time
            if (sample_half && cyc_reg == CW'(HALF_CYC - 1 - SCS_MISO_LEAD_CYC))
               ish_next = {ish_reg[6:0], miso_s};
            if (cyc_reg == CW'(HALF_CYC - 1))
            begin
               cyc_next = '0;
               half_next = half_reg + 5'd1;
               if (half_reg < 5'(SCS_HALVES))
                  sck_next = ~sck_reg;
               if (shift_half)
                  osh_next = {osh_reg[6:0], 1'b0};
               if (half_reg == last_half)
                  state_next = SCS_ST_DONE;
            end
            else
               cyc_next = cyc_reg + CW'(1);
         end
         SCS_ST_DONE:
            state_next = SCS_ST_IDLE;
         default:
            state_next = SCS_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= SCS_ST_IDLE;
         cyc_reg <= '0;
         half_reg <= 5'd0;
         sck_reg <= 1'b0;
         osh_reg <= 8'h00;
         ish_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         cyc_reg <= cyc_next;
         half_reg <= half_next;
         sck_reg <= sck_next;
         osh_reg <= osh_next;
         ish_reg <= ish_next;
      end
   end

   scs_target u_target
   (
      .link_sck(link_sck),
      .target_select_n(target_select_n),
      .sys_rst(sys_rst),
      .cfg_pol(pol_reg),
      .cfg_pha(pha_reg),
      .mosi_i(mosi_i),
      .tx_hold(txh_reg),
      .tx_req(txr_reg),
      .tx_ack(tx_ack_l),
      .rx_hold(rx_hold_l),
      .rx_toggle(rx_tog_l),
      .miso_o(miso_o)
   );

   assign sfr_rdata = rdata_reg;
   assign rx_data = rxd_reg;
   assign sck_o = sck_reg;
   assign sck_oe = role_reg;
   assign mosi_o = osh_reg[7];
   assign mosi_oe = role_reg;
   assign miso_oe = miso_oe_reg;
endmodule

// *** tb/scs_partner.sv ***
// behavioural far-side target used while the block is controller
`timescale 1ns/100ps
module scs_partner
(
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic pol,
   input wire logic pha,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   logic [3:0] cnt = 4'h0;
   logic [2:0] idx = 3'h0;
   logic idle_v = 1'b0;
   always @(negedge sel_n)
   begin
      cnt = 4'h0;
      idx = 3'h0;
   end
   // a released line shows the inverse of its last bit, never a held value
   always @(posedge sel_n)
      idle_v = ~miso;
   always @(sck)
      if (!sel_n)
      begin
         if ((sck != pol) != pha)
         begin
            rx_byte = {rx_byte[6:0], mosi};
            cnt++;
         end
         else
            idx = cnt[2:0];
      end
   assign miso = sel_n ? idle_v : tx_byte[3'h7 - idx];
endmodule

// *** tb/scs_top_asserts.sv ***
// concurrent checks on the ports of the configuration and status block
`timescale 1ns/100ps
module scs_top_asserts
   import scs_pkg::*;
#(
   parameter int HALF_CYC = SCS_SCK_HALF_CYC,
   parameter int DEGLITCH_CYC = SCS_DEGLITCH_CYC
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic tx_load,
   input wire logic [7:0] tx_data,
   input wire logic [7:0] rx_data,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic mosi_o,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic target_select_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic sck_reg;
   logic [4:0] tog_reg;
   logic [4:0] tog_next;
   // counts serial clock toggles since the last controller start
   always_comb
   begin
      tog_next = tog_reg;
      if (tx_load && sck_oe)
         tog_next = 5'h00;
      else if (sck_o != sck_reg)
         tog_next = tog_reg + 5'h01;
   end
   always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
      begin
         sck_reg <= 1'b0;
         tog_reg <= 5'h00;
      end
      else
      begin
         sck_reg <= sck_o;
         tog_reg <= tog_next;
      end
   sequence s_go;
      tx_load && sck_oe;
   endsequence
   sequence s_cfg_rd;
      sfr_rd && sfr_addr == SCS_CFG_ADDR;
   endsequence
   a_role_write: assert property (sfr_wr && sfr_addr == SCS_CFG_ADDR |=>
      ##1 sck_oe == $past(sfr_wdata[SCS_BIT_ROLE], 2))
      else $error("role bit not on drivers");
   a_role_drivers: assert property (sck_oe == mosi_oe && !(miso_oe && sck_oe))
      else $error("driver enables disagree");
   a_sck_pace: assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o) [*3])
      else $error("clock half too short");
   a_msb_first: assert property (s_go |=> mosi_o == $past(tx_data[7]))
      else $error("first bit not msb");
   a_tog_count: assert property ($changed(rx_data) && sck_oe |-> tog_next == 5'h10)
      else $error("byte ended off sixteen toggles");
   // two sync flops, the deglitch window and the enable register take seven edges
   a_sel_release: assert property (target_select_n [*8] |-> !miso_oe)
      else $error("miso driven while not selected");
   a_busy_read: assert property (s_go ##2 s_cfg_rd |=> sfr_rdata[SCS_BIT_ACTIVE])
      else $error("busy not shown");
   a_ctl_empty: assert property ((s_cfg_rd and sck_oe) |=> sfr_rdata[1:0] == 2'b11)
      else $error("empty flags low as controller");
endmodule
bind scs_top scs_top_asserts #(.HALF_CYC(HALF_CYC), .DEGLITCH_CYC(DEGLITCH_CYC)) scs_top_asserts_inst
(
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata),
   .sfr_rdata(sfr_rdata),
   .tx_load(tx_load),
   .tx_data(tx_data),
   .rx_data(rx_data),
   .sck_o(sck_o),
   .sck_oe(sck_oe),
   .mosi_o(mosi_o),
   .mosi_oe(mosi_oe),
   .miso_oe(miso_oe),
   .target_select_n(target_select_n)
);

// *** tb/scs_top_tb.sv ***
// self-checking bench: register access, controller and target bytes in every mode
`timescale 1ns/100ps
module scs_top_tb
   import scs_pkg::*;
;
   logic core_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic tx_load = 1'b0, rx_read = 1'b0, tb_sck = 1'b0, tb_mosi = 1'b0;
   logic tsel_n = 1'b1, psel_n = 1'b1, pol = 1'b0, pha = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, tx_data = 8'h00, p_tx = 8'h00;
   logic [7:0] sfr_rdata, rx_data, p_rx;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso;
   int bad_count = 0;
   int n_tests = 0;
   wire sck_w = sck_oe ? sck_o : tb_sck;
   wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
   wire miso_w = miso_oe ? miso_o : p_miso;
   scs_top #(.HALF_CYC(4), .DEGLITCH_CYC(2)) scs_top_inst
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_load(tx_load),
      .tx_data(tx_data), .rx_read(rx_read), .rx_data(rx_data), .link_sck(sck_w),
      .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .target_select_n(tsel_n)
   );
   scs_partner scs_partner_inst
   (
      .sck(sck_w), .mosi(mosi_w), .sel_n(psel_n), .pol(pol), .pha(pha),
      .tx_byte(p_tx), .miso(p_miso), .rx_byte(p_rx)
   );
   initial
   begin
      forever #12.5 core_clk = !core_clk;
   end
   task cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = w;
      sfr_rd = !w;
      @(negedge core_clk);
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      @(negedge core_clk);
      v = sfr_rdata;
   endtask
   task wr(input logic [7:0] d);
      logic [7:0] v;
      bus(1'b1, SCS_CFG_ADDR, d, v);
   endtask
   task status(input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] v;
      bus(1'b0, SCS_CFG_ADDR, 8'h00, v);
      cmp8(v & m, exp);
   endtask
   task load(input logic [7:0] d);
      @(negedge core_clk);
      tx_data = d;
      tx_load = 1'b1;
      @(negedge core_clk);
      tx_load = 1'b0;
   endtask
   task t_regs;
      logic [7:0] v;
      status(8'hFF, SCS_CFG_RESET);
      wr(8'h8F);
      status(8'hFF, 8'h07);
      wr(8'h30);
      bus(1'b1, 8'h55, 8'h00, v);
      status(8'hFF, 8'h37);
      bus(1'b0, 8'h55, 8'h00, v);
      cmp8(v, SCS_UNMAPPED_READ);
      // one short low pulse must not reach the filtered flag
      #5 tsel_n = 1'b0;
      #15 tsel_n = 1'b1;
      status(8'h08, 8'h00);
   endtask
   task t_ctl(input logic [1:0] m, input logic [7:0] d, input logic [7:0] pd);
      {pha, pol} = m;
      wr({2'b01, m, 4'h0});
      repeat (2) @(negedge core_clk);
      cmp8({7'h00, sck_o}, {7'h00, pol});
      status(8'hFF, {2'b01, m, 4'h7});
      cmp8({6'h00, sck_oe, mosi_oe}, 8'h03);
      p_tx = pd;
      psel_n = 1'b0;
      load(d);
      status(8'h80, 8'h80);
      repeat ((16 + pha) * 4 + 2) @(negedge core_clk);
      cmp8(rx_data, pd);
      cmp8(p_rx, d);
      cmp8({7'h00, sck_o}, {7'h00, pol});
      status(8'hFF, {2'b01, m, 4'h7});
      psel_n = 1'b1;
   endtask
   task t_tgt(input logic [1:0] m, input logic [7:0] d, input logic [7:0] td);
      logic [7:0] got;
      int k;
      {pha, pol} = m;
      wr({2'b00, m, 4'h0});
      tb_sck = pol;
      load(td);
      tb_mosi = d[7];
      tsel_n = 1'b0;
      repeat (6) @(negedge core_clk);
      status(8'h8C, 8'h88);
      cmp8({7'h00, miso_oe}, 8'h01);
      k = 0;
      got = 8'h00;
      // the link clock runs only inside the frame, off the core clock phase
      #7;
      for (int e = 0; e < 16; e++)
      begin
         #24;
         if ((e % 2 == 0) != pha)
         begin
            got = {got[6:0], miso_o};
            k++;
         end
         else if (k < 8)
            tb_mosi = d[7 - k];
         tb_sck = !tb_sck;
      end
      #24;
      tb_mosi = !tb_mosi;
      tsel_n = 1'b1;
      repeat (10) @(negedge core_clk);
      cmp8(rx_data, d);
      cmp8(got, td);
      status(8'hFF, {2'b00, m, 4'h6});
      @(negedge core_clk);
      rx_read = 1'b1;
      @(negedge core_clk);
      rx_read = 1'b0;
      status(8'h03, 8'h03);
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      t_regs;
      for (int i = 0; i < 4; i++)
      begin
         t_ctl(i[1:0], 8'h96 ^ {4{i[1:0]}}, 8'h3C + i[7:0]);
         t_tgt(i[1:0], 8'hA5 + i[7:0], 8'h5A ^ {4{i[1:0]}});
      end
      close_out;
   end
   // the whole sequence needs about 560 core cycles; this is many times that
   initial
   begin
      #400000;
      bad_count++;
      close_out;
   end
endmodule
